/* sfep_consts.vh */
// Purpose: constants for the serial flash controller
// Assumes: host side, SPI mode 0
// Notes: opcodes other than 52h and ABh are plain defaults
`ifndef SFEP_CONSTS_VH
`define SFEP_CONSTS_VH
`define SFEP_OP_WRITE_ENABLE_CMD 8'h06
`define SFEP_OP_RDSR 8'h05
`define SFEP_OP_DREAD2 8'hBB
`define SFEP_OP_SECT 8'h20
`define SFEP_OP_B32 8'h52
`define SFEP_OP_B64 8'hD8
`define SFEP_OP_CHIP 8'h60
`define SFEP_OP_PROG 8'h02
`define SFEP_OP_PDN 8'hB9
`define SFEP_OP_REL 8'hAB
`define SFEP_OP_ARM 8'h66
`define SFEP_OP_RST 8'h99
`define SFEP_CMD_READ 4'h0
`define SFEP_CMD_SECT 4'h1
`define SFEP_CMD_B32 4'h2
`define SFEP_CMD_B64 4'h3
`define SFEP_CMD_CHIP 4'h4
`define SFEP_CMD_PROG 4'h5
`define SFEP_CMD_PDN 4'h6
`define SFEP_CMD_REL 4'h7
`define SFEP_CMD_SIG 4'h8
`define SFEP_CMD_RESET 4'h9
`define SFEP_CMD_STATUS 4'hA
`define SFEP_SR_BUSY 0
`define SFEP_SR_WEL 1
`define SFEP_DUMMY_CLKS 8'h04
`define SFEP_ADDR_BITS 8'h18
`define SFEP_OP_BITS 13'h0008
`define SFEP_STAT_BITS 13'h0010
`define SFEP_HDR_BITS 13'h0020
`define SFEP_SIG_BITS 13'h0028
`define SFEP_RD_ADDR_END 13'h0014
`define SFEP_RD_DATA_AT 13'h0018
`define SFEP_WAKE_NS 8800
`define SFEP_PDN_NS 10000
`define SFEP_CLK_NS 4
`endif

/* sfep_ctrl.v */
// Purpose: host controller that drives a serial NOR flash over SPI mode 0
// Assumes: one command at a time from the user port; 250 MHz clock
// Notes: dual pins are split into in, out and output enable
`timescale 1ns/1ps
`include "sfep_consts.vh"
module sfep_ctrl #(
  parameter DIV = 8,
  parameter WAKE_CYC = (`SFEP_WAKE_NS + `SFEP_CLK_NS - 1) / `SFEP_CLK_NS,
  parameter PDN_CYC = (`SFEP_PDN_NS + `SFEP_CLK_NS - 1) / `SFEP_CLK_NS
) (
  input wire clk,
  input wire rst,
  input wire cmd_valid,
  input wire [3:0] cmd_code,
  input wire [23:0] cmd_addr,
  input wire [8:0] cmd_len,
  input wire [7:0] cmd_wdata,
  output reg cmd_ready,
  output reg wdata_take,
  output reg [7:0] rdata,
  output reg rdata_valid,
  output reg done,
  output reg busy_seen,
  output reg [7:0] status_q,
  output reg cs_n,
  output reg sclk,
  output reg io0_out,
  output reg io0_oe,
  output reg io1_out,
  output reg io1_oe,
  input wire io0_in,
  input wire io1_in
);
  localparam S_IDLE = 6'b000001;
  localparam S_SHIFT = 6'b000010;
  localparam S_GAP = 6'b000100;
  localparam S_POLL = 6'b001000;
  localparam S_WAIT = 6'b010000;
  localparam S_DONE = 6'b100000;

  reg [5:0] st_q;
  reg [3:0] cmd_q;
  reg [23:0] addr_q;
  reg [8:0] len_q;
  reg [1:0] phase_q;
  reg [39:0] fr_q;
  reg [12:0] rc_q;
  reg [12:0] tot_q;
  reg stat_q;
  reg srx_q;
  reg [7:0] gap_op;
  reg [12:0] gap_len;
  reg gap_adv;
  reg gap_stat;
  reg gap_srx;
  reg [7:0] rsh_q;
  reg [3:0] rbits_q;
  reg dual_q;
  reg is_rx_q;
  reg [7:0] div_q;
  reg [15:0] wait_q;
  reg [1:0] s0_q, s1_q;
  wire tick = (div_q == DIV[7:0] - 8'h01);
  wire need_wel = (cmd_q == `SFEP_CMD_SECT) || (cmd_q == `SFEP_CMD_B32) ||
    (cmd_q == `SFEP_CMD_B64) || (cmd_q == `SFEP_CMD_CHIP) || (cmd_q == `SFEP_CMD_PROG);

  // Opcode of the main step for a command
  function [7:0] op_of;
    input [3:0] c;
    begin
      case (c)
        `SFEP_CMD_READ: op_of = `SFEP_OP_DREAD2;
        `SFEP_CMD_SECT: op_of = `SFEP_OP_SECT;
        `SFEP_CMD_B32: op_of = `SFEP_OP_B32;
        `SFEP_CMD_B64: op_of = `SFEP_OP_B64;
        `SFEP_CMD_CHIP: op_of = `SFEP_OP_CHIP;
        `SFEP_CMD_PROG: op_of = `SFEP_OP_PROG;
        `SFEP_CMD_PDN: op_of = `SFEP_OP_PDN;
        `SFEP_CMD_RESET: op_of = `SFEP_OP_RST;
        `SFEP_CMD_STATUS: op_of = `SFEP_OP_RDSR;
        default: op_of = `SFEP_OP_REL;
      endcase
    end
  endfunction

  // Opcode, length in rising edges and receive plan of the next frame
  always @* begin
    gap_op = op_of(cmd_q);
    gap_len = `SFEP_HDR_BITS;
    gap_adv = (phase_q != 2'h3);
    gap_stat = 1'b0;
    gap_srx = 1'b0;
    if (phase_q == 2'h0 && need_wel) begin
      gap_op = `SFEP_OP_WRITE_ENABLE_CMD;
      gap_len = `SFEP_OP_BITS;
      gap_adv = 1'b0;
    end else if (phase_q == 2'h0 && cmd_q == `SFEP_CMD_RESET) begin
      gap_op = `SFEP_OP_ARM;
      gap_len = `SFEP_OP_BITS;
      gap_adv = 1'b0;
    end else if (cmd_q == `SFEP_CMD_STATUS ||
        (phase_q == 2'h0 && cmd_q == `SFEP_CMD_READ)) begin
      gap_op = `SFEP_OP_RDSR;
      gap_len = `SFEP_STAT_BITS;
      gap_adv = gap_adv && (cmd_q == `SFEP_CMD_STATUS);
      gap_stat = 1'b1;
      gap_srx = 1'b1;
    end else if (cmd_q == `SFEP_CMD_CHIP || cmd_q == `SFEP_CMD_PDN ||
        cmd_q == `SFEP_CMD_REL || cmd_q == `SFEP_CMD_RESET) begin
      gap_len = `SFEP_OP_BITS;
    end else if (cmd_q == `SFEP_CMD_SIG) begin
      gap_len = `SFEP_SIG_BITS;
      gap_srx = 1'b1;
    end else if (cmd_q == `SFEP_CMD_READ) begin
      gap_len = `SFEP_RD_DATA_AT + {2'b00, len_q, 2'b00};
    end else if (cmd_q == `SFEP_CMD_PROG) begin
      gap_len = `SFEP_HDR_BITS + {1'b0, len_q, 3'b000};
    end
  end

  // Input synchronisers for the data pins
  always @(posedge clk) begin
    s0_q <= {s0_q[0], io0_in};
    s1_q <= {s1_q[0], io1_in};
  end

  // Serial clock divider, one tick per half period
  always @(posedge clk) begin
    if (rst || st_q != S_SHIFT || tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // Main sequencer
  always @(posedge clk) begin
    if (rst) begin
      st_q <= S_IDLE;
      cmd_q <= 4'h0;
      addr_q <= 24'h000000;
      len_q <= 9'h000;
      phase_q <= 2'h0;
      fr_q <= 40'h0000000000;
      rc_q <= 13'h0000;
      tot_q <= 13'h0000;
      stat_q <= 1'b0;
      srx_q <= 1'b0;
      rsh_q <= 8'h00;
      rbits_q <= 4'h0;
      dual_q <= 1'b0;
      is_rx_q <= 1'b0;
      wait_q <= 16'h0000;
      cmd_ready <= 1'b0;
      wdata_take <= 1'b0;
      rdata <= 8'h00;
      rdata_valid <= 1'b0;
      done <= 1'b0;
      busy_seen <= 1'b0;
      status_q <= 8'h00;
      cs_n <= 1'b1;
      sclk <= 1'b0;
      io0_out <= 1'b0;
      io0_oe <= 1'b0;
      io1_out <= 1'b0;
      io1_oe <= 1'b0;
    end else begin
      wdata_take <= 1'b0;
      rdata_valid <= 1'b0;
      done <= 1'b0;
      case (st_q)
        S_IDLE: begin
          cmd_ready <= 1'b1;
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            busy_seen <= 1'b0;
            cmd_q <= cmd_code;
            addr_q <= cmd_addr;
            len_q <= (cmd_len == 9'h000) ? 9'h001 : cmd_len;
            phase_q <= 2'h0;
            st_q <= S_GAP;
          end
        end
        S_GAP: begin
          // Phase 0 sends write enable or reset enable first where needed, or busy poll for reads
          cs_n <= 1'b0;
          io0_oe <= 1'b1;
          io1_oe <= 1'b0;
          dual_q <= 1'b0;
          is_rx_q <= 1'b0;
          st_q <= S_SHIFT;
          rc_q <= 13'h0000;
          rbits_q <= 4'h0;
          tot_q <= gap_len;
          stat_q <= gap_stat;
          srx_q <= gap_srx;
          // First bit stands before the first rising edge, as mode 0 needs
          io0_out <= gap_op[7];
          fr_q <= {gap_op[6:0], addr_q, 9'h000};
          if (gap_adv) begin
            phase_q <= 2'h1;
          end
        end
        S_SHIFT: begin
          if (tick) begin
            sclk <= ~sclk;
            if (!sclk) begin
              // Rising edge: count it and plan the lanes for what follows
              rc_q <= rc_q + 13'h0001;
              if (cmd_q == `SFEP_CMD_READ && phase_q == 2'h1 &&
                  rc_q == `SFEP_OP_BITS - 13'h0001) begin
                dual_q <= 1'b1;
                io1_oe <= 1'b1;
              end
              if ((srx_q && rc_q == `SFEP_OP_BITS) ||
                  (cmd_q == `SFEP_CMD_READ && phase_q == 2'h1 && rc_q == `SFEP_RD_DATA_AT)) begin
                is_rx_q <= 1'b1;
              end
            end else begin
              // Falling edge: take the bits of the last rise, then present the next
              if (is_rx_q) begin
                rsh_q <= dual_q ? {rsh_q[5:0], s1_q[1], s0_q[1]} : {rsh_q[6:0], s1_q[1]};
                rbits_q <= rbits_q + (dual_q ? 4'h2 : 4'h1);
                if (rbits_q + (dual_q ? 4'h2 : 4'h1) == 4'h8) begin
                  rbits_q <= 4'h0;
                  if (stat_q) begin
                    status_q <= {rsh_q[6:0], s1_q[1]};
                  end else begin
                    rdata <= dual_q ? {rsh_q[5:0], s1_q[1], s0_q[1]} : {rsh_q[6:0], s1_q[1]};
                    rdata_valid <= 1'b1;
                  end
                end
              end
              if (cmd_q == `SFEP_CMD_READ && phase_q == 2'h1 && rc_q == `SFEP_RD_ADDR_END) begin
                io0_oe <= 1'b0;
                io1_oe <= 1'b0;
              end
              if (rc_q == tot_q) begin
                st_q <= S_POLL;
              end else if (dual_q) begin
                {io1_out, io0_out} <= fr_q[39:38];
                fr_q <= {fr_q[37:0], 2'b00};
              end else if (cmd_q == `SFEP_CMD_PROG && rc_q >= `SFEP_HDR_BITS &&
                  rc_q[2:0] == 3'h0) begin
                // Next data byte; the user has it standing since the last take
                io0_out <= cmd_wdata[7];
                fr_q <= {cmd_wdata[6:0], 33'h000000000};
                wdata_take <= 1'b1;
              end else begin
                io0_out <= fr_q[39];
                fr_q <= {fr_q[38:0], 1'b0};
              end
            end
          end
        end
        S_POLL: begin
          // Raise select; decide next phase
          cs_n <= 1'b1;
          sclk <= 1'b0;
          io0_oe <= 1'b0;
          io1_oe <= 1'b0;
          if (phase_q == 2'h0 && cmd_q == `SFEP_CMD_READ && status_q[`SFEP_SR_BUSY]) begin
            busy_seen <= 1'b1;
            st_q <= S_GAP;
          end else if (phase_q == 2'h0) begin
            phase_q <= 2'h1;
            st_q <= S_GAP;
          end else if (need_wel) begin
            // Poll status until the internal cycle ends
            cmd_q <= `SFEP_CMD_STATUS;
            is_rx_q <= 1'b0;
            phase_q <= 2'h3;
            st_q <= S_GAP;
          end else if (phase_q == 2'h3 && status_q[`SFEP_SR_BUSY]) begin
            busy_seen <= 1'b1;
            st_q <= S_GAP;
          end else begin
            wait_q <= (cmd_q == `SFEP_CMD_PDN) ? PDN_CYC[15:0] : WAKE_CYC[15:0];
            st_q <= S_WAIT;
          end
        end
        S_WAIT: begin
          // Hold select high for the entry or wake delay
          if (wait_q == 16'h0000) begin
            st_q <= S_DONE;
          end else begin
            wait_q <= wait_q - 16'h0001;
          end
        end
        S_DONE: begin
          done <= 1'b1;
          st_q <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule // sfep_ctrl

/* sfep_ctrl_asserts.sv */
// Purpose: port checks for the flash controller
// Assumes: mode 0 framing, one clock
// Notes: bound into the controller
`timescale 1ns/1ps
module sfep_chk (
  input wire clk,
  input wire rst,
  input wire cmd_valid,
  input wire cmd_ready,
  input wire wdata_take,
  input wire rdata_valid,
  input wire done,
  input wire cs_n,
  input wire sclk,
  input wire io1_oe
);
  reg [11:0] n_q = 12'h000;
  reg s_q = 1'b0;
  reg d_q = 1'b0;
  // Clock rises in a frame, two-line frames
  always @(posedge clk) begin
    s_q <= sclk;
    n_q <= (rst | cs_n) ? 12'h000 : n_q + {11'h000, sclk & !s_q};
    d_q <= !(rst | cs_n) & (d_q | io1_oe);
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_reset_idle: assert property ($fell(rst) |-> cs_n && !sclk)
    else $error("bus not idle after reset");
  a_ready_up: assert property ($fell(rst) |-> ##[1:2] cmd_ready)
    else $error("ready late after reset");
  a_take_once: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
    else $error("ready stayed up after take");
  a_done_pulse: assert property (done |=> !done)
    else $error("done longer than a cycle");
  a_take_pulse: assert property (wdata_take |=> !wdata_take)
    else $error("data take longer than a cycle");
  a_byte_edge: assert property ($rose(cs_n) && !d_q |-> n_q[2:0] == 3'h0)
    else $error("select rose off a byte edge");
  a_addr_lines: assert property ($fell(io1_oe) && !cs_n |-> n_q >= 20 && n_q <= 24)
    else $error("address lines released at wrong count");
  a_data_late: assert property (rdata_valid && d_q |-> n_q >= 28)
    else $error("read byte before dummy clocks");
endmodule // sfep_chk
bind sfep_ctrl sfep_chk chk_u (.*);

/* sfep_flash.sv */
// Purpose: behavioural serial flash partner
// Assumes: mode 0, 64K array, protect bits clear
// Notes: busy time counted in bench clocks
`timescale 1ns/1ps
`include "sfep_consts.vh"
module sfep_flash #(
  parameter BUSYC = 60,
  parameter SIG = 8'h3C // Arbitrary code
) (
  input wire clk,
  input wire cs_n,
  input wire sclk,
  input wire [1:0] din,
  output reg [1:0] dout,
  output wire doe
);
  reg [7:0] mem [0:65535];
  reg [7:0] pg [0:255];
  reg [255:0] pv;
  reg [7:0] op, b, r;
  reg [23:0] a;
  reg oe, write_enable_latch, pd, arm;
  integer n, bz, i, k, e;
  wire [7:0] sr = {6'h00, write_enable_latch, bz != 0};
  assign doe = oe & !cs_n;
  // Erased array, standby
  initial begin
    for (i = 0; i < 65536; i = i + 1) mem[i] = 8'hFF;
    {write_enable_latch, pd, arm, bz, n} = 0;
  end
  // Self-timed cycle
  always @(posedge clk) if (bz > 0) begin
    bz = bz - 1;
    write_enable_latch = write_enable_latch & bz > 0;
  end
  always @(negedge cs_n) {n, pv} = 0;
  // Shift in opcode, address, data
  always @(posedge sclk) if (!cs_n) begin
    if (n < 8) op = {op[6:0], din[0]};
    else if (op == `SFEP_OP_DREAD2) a = n < 20 ? {a[21:0], din} : a;
    else if (n < 32) a = {a[22:0], din[0]};
    else b = {b[6:0], din[0]};
    k = (a[7:0] + n / 8 - 4) & 255;
    if (n > 31 && n % 8 == 7) {pv[k], pg[k]} = {1'b1, b};
    n = n + 1;
  end
  // Drive status, code, read data
  always @(negedge sclk) if (!cs_n) begin
    r = mem[(a[15:0] + n / 4 - 6) & 65535];
    oe = n > 7 && op == `SFEP_OP_RDSR && !pd;
    dout = {sr[7 - n % 8], 1'b0};
    if (n > 7 && op == `SFEP_OP_REL) {oe, dout} = {1'b1, SIG[7 - n % 8], 1'b0};
    if (n > 23 && op == `SFEP_OP_DREAD2 && bz == 0 && !pd)
      {oe, dout} = {1'b1, r[7 - 2 * (n % 4) -: 2]};
  end
  // Act on whole frames only
  always @(posedge cs_n) begin
    {k, e} = {31'h0, arm, 32'h0};
    arm = 0;
    if (pd) pd = op != `SFEP_OP_REL;
    else if (n == 8 && op == `SFEP_OP_RST && k) {write_enable_latch, bz} = 0;
    else if (n == 8 && bz == 0) begin
      arm = op == `SFEP_OP_ARM;
      write_enable_latch = write_enable_latch | op == `SFEP_OP_WRITE_ENABLE_CMD;
      pd = op == `SFEP_OP_PDN;
      e = op == `SFEP_OP_CHIP ? 65536 : 0;
    end else if (n == 32 && bz == 0)
      e = op == `SFEP_OP_SECT ? 4096 : op == `SFEP_OP_B32 ? 32768 :
        op == `SFEP_OP_B64 ? 65536 : 0;
    for (i = 0; i < e && write_enable_latch; i = i + 1) mem[a[15:0] - a[15:0] % e + i] = 8'hFF;
    if (op == `SFEP_OP_PROG && bz == 0 && !pd && n > 32 && n % 8 == 0) e = 1;
    for (i = 0; i < 256 && e == 1 && write_enable_latch; i = i + 1) if (pv[i]) mem[a[15:8] * 256 + i] = pg[i];
    if (write_enable_latch && e > 0) bz = BUSYC;
  end
endmodule // sfep_flash

/* testbench.sv */
// Purpose: self-checking bench for the flash controller
// Assumes: partner flash model, 250 MHz clock
// Notes: data checked through dual read
`timescale 1ns/1ps
`include "sfep_consts.vh"
module testbench;
  localparam [7:0] SIGV = 8'h3C;
  localparam [27:0] SEQ = 28'h9768643;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg cmd_valid = 1'b0;
  reg [3:0] cmd_code = 4'h0;
  reg [23:0] cmd_addr = 24'h000000;
  reg [8:0] cmd_len = 9'h000;
  reg [7:0] cmd_wdata = 8'h00;
  reg [7:0] s = 8'h58;
  reg [7:0] wq [0:511];
  reg [7:0] rq [$];
  reg [23:0] pa;
  reg [8:0] pl;
  integer num_errors = 0;
  integer checked = 0;
  integer cyc = 0;
  integer wi = 0;
  integer p, i;
  wire cmd_ready, wdata_take, rdata_valid, done, busy_seen, cs_n, sclk, moe;
  wire io0_out, io0_oe, io1_out, io1_oe;
  wire [7:0] rdata, status_q;
  wire [1:0] md;
  // Released lines show a moving pattern
  wire io0_in = io0_oe ? io0_out : moe ? md[0] : clk;
  wire io1_in = io1_oe ? io1_out : moe ? md[1] : clk;
  sfep_ctrl #(.DIV(8), .WAKE_CYC(4), .PDN_CYC(4)) dut_u (.*);
  sfep_flash #(.BUSYC(400), .SIG(SIGV)) fl_u (.clk(clk), .cs_n(cs_n), .sclk(sclk),
    .din({io1_in, io0_in}), .dout(md), .doe(moe));
  function [7:0] lfsr(input [7:0] v);
    lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // Byte left at offset o after l bytes from offset a
  function [7:0] pexp(input [7:0] a, input [8:0] l, input [7:0] o);
    integer k;
    begin
      k = (o - a) & 255;
      while (k + 256 < l) k = k + 256;
      pexp = k < l ? wq[k] : 8'hFF;
    end
  endfunction
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task run(input [3:0] c, input [23:0] a, input [8:0] l);
    begin
      while (cmd_ready !== 1'b1) @(negedge clk);
      @(posedge clk);
      {cmd_code, cmd_addr, cmd_len, cmd_valid} <= {c, a, l, 1'b1};
      @(posedge clk);
      cmd_valid <= 1'b0;
      @(negedge clk);
      while (done !== 1'b1) @(negedge clk);
    end
  endtask
  task rd2(input [23:0] a, input [7:0] e0, input [7:0] e1);
    begin
      rq.delete();
      run(`SFEP_CMD_READ, a, 9'h002);
      chk(rq.size(), 2);
      chk({rq[0], rq[1]}, {e0, e1});
    end
  endtask
  task close_out;
    begin
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial forever #2 clk = ~clk;
  // Collect read bytes, feed program bytes, cut hangs
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (rdata_valid === 1'b1) rq.push_back(rdata);
    if (wdata_take === 1'b1) wi <= wi + 1;
    if (wdata_take === 1'b1) cmd_wdata <= wq[wi + 1];
    if (cyc == 95000) num_errors = num_errors + 1;
    if (cyc == 95000) close_out;
  end
  // Programs with wrap and overflow, erases, power modes
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (p = 0; p < 2; p = p + 1) begin
      for (i = 0; i < 512; i = i + 1) begin
        s = lfsr(s);
        wq[i] = s;
      end
      pa = p ? 24'h0010FE : 24'h000200;
      pl = p ? 9'h004 : 9'h102;
      {wi, cmd_wdata} <= {32'h0, wq[0]};
      run(`SFEP_CMD_PROG, pa, pl);
      rd2({pa[23:8], 8'h00}, pexp(pa[7:0], pl, 8'h00), pexp(pa[7:0], pl, 8'h01));
      rd2({pa[23:8], 8'hFE}, pexp(pa[7:0], pl, 8'hFE), pexp(pa[7:0], pl, 8'hFF));
    end
    run(`SFEP_CMD_SECT, 24'h000234, 9'h001);
    chk(busy_seen, 1);
    rd2(24'h000200, 8'hFF, 8'hFF);
    rd2(24'h0010FE, wq[0], wq[1]);
    run(`SFEP_CMD_B32, 24'h001234, 9'h001);
    rd2(24'h0010FE, 8'hFF, 8'hFF);
    for (p = 0; p < 7; p = p + 1) begin
      rq.delete();
      run(SEQ[p * 4 +: 4], 24'h000000, 9'h001);
      if (p < 2) chk(busy_seen, 1);
      if (p == 3) chk(rq[rq.size() - 1], SIGV);
    end
    rd2(24'h0000FE, 8'hFF, 8'hFF);
    close_out;
  end
endmodule // testbench
